// ==== rtl/lmc_pkg.sv ====
/*
 * Constants, commands, memory map and state type of the logger
 * memory/control command unit.
 * Assumes a 10 MHz core clock and a byte-level link front end.
 */
package lmc_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_WSPAD = 8'h0f;
	localparam logic [7:0] CMD_RSPAD = 8'haa;
	localparam logic [7:0] CMD_COPY = 8'h99;
	localparam logic [7:0] CMD_RMEM = 8'h69;
	localparam logic [7:0] CMD_CLEAR = 8'h96;
	localparam logic [7:0] CMD_CONV = 8'h55;
	localparam logic [7:0] CMD_START = 8'hcc;
	localparam logic [7:0] CMD_STOP = 8'h33;

	// ----------------------------------------------------------------
	// End/status byte layout
	// ----------------------------------------------------------------
	localparam int ES_ACC_BIT = 7;
	localparam int ES_ZERO_BIT = 6;
	localparam int ES_PART_BIT = 5;
	localparam logic [4:0] OFF_LAST = 5'h1f;

	// ----------------------------------------------------------------
	// Memory map
	// ----------------------------------------------------------------
	localparam logic [15:0] REGP_LO = 16'h0200;
	localparam logic [15:0] REGP_HI = 16'h023f;
	localparam logic [15:0] PW_LO = 16'h0227;
	localparam logic [15:0] PW_HI = 16'h0236;
	localparam logic [15:0] RSV_LO = 16'h0280;
	localparam logic [15:0] RSV_HI = 16'h0fff;
	localparam logic [15:0] MEM_LAST = 16'h2fff;
	localparam int MEM_AW = 14;
	localparam int SP_AW = 5;

	// ----------------------------------------------------------------
	// Fill bytes and CRC
	// ----------------------------------------------------------------
	localparam logic [7:0] FILL_ONES = 8'hff;
	localparam logic [7:0] FILL_ALT = 8'h55;
	localparam logic [7:0] FILL_PW = 8'h00;
	localparam logic [7:0] FILL_RSV = 8'hff;
	localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
	localparam logic [15:0] CRC_CLEAR = 16'h0000;

	// ----------------------------------------------------------------
	// Byte counts
	// ----------------------------------------------------------------
	localparam logic [3:0] PW_LAST_IDX = 4'h7;
	localparam logic [3:0] AUTH_LAST_IDX = 4'h2;
	localparam logic [3:0] HDR_BYTES = 4'h3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int COPY_NS_PER_BYTE = 2000;
	localparam int COPY_CYC = COPY_NS_PER_BYTE / CLK_NS;
	localparam int CONV_MAX_MS = 600;
	localparam int CONV_MAX_CYC = CONV_MAX_MS * 1000000 / CLK_NS;
	localparam int CNT_W = 23;

	typedef enum logic [3:0] {
		ST_CMD, ST_TGT_LO, ST_TGT_HI, ST_WDATA, ST_AUTH, ST_PW, ST_DUMMY,
		ST_RSP, ST_RMEM, ST_COPY, ST_CONV, ST_ONES, ST_ALT, ST_DEAD
	} lmc_state_t;

endpackage

// ==== rtl/lmc_mem.sv ====
/*
 * Simple dual-port byte memory with registered read data.
 * Assumes one write and one read per clock, no reset of contents.
 */
`timescale 1ns/1ns
`default_nettype none
module lmc_mem #(
	parameter int AW = 5,
	parameter int DW = 8
) (
	// Clock
	input wire logic clk_i,
	// Write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	// Read port
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem_q [0:(1<<AW)-1];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_q[raddr_i];
	end
endmodule
`default_nettype wire

// ==== rtl/lmc_cmd_unit.sv ====
/*
 * Memory and control command interpreter of a temperature logger.
 * Assumes a link front end that delivers whole received bytes, flags
 * partial bytes, requests one transmit byte per read and reports the
 * bus reset pulse; sampling and the mission registers live outside.
 */
`timescale 1ns/1ns
`default_nettype none
module lmc_cmd_unit import lmc_pkg::*; #(
	parameter int unsigned CONV_MAX_CYC_P = CONV_MAX_CYC
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Byte link
	input wire logic bus_reset_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_partial_i,
	input wire logic tx_req_i,
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	// Passwords
	input wire logic pw_enable_i,
	input wire logic [63:0] read_pw_i,
	input wire logic [63:0] full_pw_i,
	// Mission control
	input wire logic alarm_start_mode_i,
	input wire logic alarm_hit_i,
	output logic mission_in_progress_o,
	output logic waiting_for_alarm_o,
	output logic memory_cleared_o,
	output logic reg_pages_writable_o,
	output logic authorization_accepted_o,
	output logic mission_start_o,
	output logic mission_clear_o,
	output logic alarm_log_o,
	output logic copy_busy_o,
	// Conversion
	input wire logic conv_done_i,
	input wire logic [15:0] conv_result_i,
	output logic conv_start_o,
	output logic [15:0] latest_result_o
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			fb = r[0] ^ b[i];
			r = r >> 1;
			if (fb) begin
				r = r ^ CRC_POLY_REFL;
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] map_rd(input logic [15:0] a,
		input logic [7:0] raw);
		if (a >= PW_LO && a <= PW_HI) begin
			return FILL_PW;
		end else if (a > MEM_LAST || (a >= RSV_LO && a <= RSV_HI)) begin
			return FILL_RSV;
		end
		return raw;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	lmc_state_t st_q, st_d;
	logic [7:0] cmd_q, cmd_d;
	logic [15:0] ta_q, ta_d, addr_q, addr_d, crc_q, crc_d;
	logic [4:0] es_off_q, es_off_d, ptr_q, ptr_d;
	logic partial_q, partial_d, accepted_q, accepted_d, full_q, full_d;
	logic [3:0] idx_q, idx_d;
	logic [63:0] pw_q, pw_d;
	logic [23:0] auth_q, auth_d;
	logic [1:0] crcph_q, crcph_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic tx_valid_d, mission_d, waiting_d, cleared_d;
	logic mstart_d, mclr_d, cstart_d, alog_d;
	logic [7:0] tx_byte_d;
	logic [15:0] latest_d;
	logic sp_we, mem_we;
	logic [7:0] sp_rdata, mem_rdata, es_byte;
	logic [63:0] pw_v;
	logic full_ok, read_ok;

	assign es_byte = {accepted_q, 1'b0, partial_q, es_off_q};
	assign pw_v = {rx_byte_i, pw_q[63:8]};
	assign full_ok = !pw_enable_i || pw_v == full_pw_i;
	assign read_ok = full_ok || pw_v == read_pw_i;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	lmc_mem #(.AW(SP_AW), .DW(8)) u_spad (
		.clk_i(mclk_i),
		.we_i(sp_we),
		.waddr_i(ptr_q),
		.wdata_i(rx_byte_i),
		.raddr_i(ptr_q),
		.rdata_o(sp_rdata)
	);

	lmc_mem #(.AW(MEM_AW), .DW(8)) u_data (
		.clk_i(mclk_i),
		.we_i(mem_we),
		.waddr_i(addr_q[MEM_AW-1:0]),
		.wdata_i(sp_rdata),
		.raddr_i(addr_q[MEM_AW-1:0]),
		.rdata_o(mem_rdata)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		ta_d = ta_q;
		addr_d = addr_q;
		crc_d = crc_q;
		es_off_d = es_off_q;
		ptr_d = ptr_q;
		partial_d = partial_q;
		accepted_d = accepted_q;
		full_d = full_q;
		idx_d = idx_q;
		pw_d = pw_q;
		auth_d = auth_q;
		crcph_d = crcph_q;
		cnt_d = cnt_q;
		mission_d = mission_in_progress_o;
		waiting_d = waiting_for_alarm_o;
		cleared_d = memory_cleared_o;
		latest_d = latest_result_o;
		tx_valid_d = 1'b0;
		tx_byte_d = tx_byte_o;
		mstart_d = 1'b0;
		mclr_d = 1'b0;
		cstart_d = 1'b0;
		alog_d = 1'b0;
		sp_we = 1'b0;
		mem_we = 1'b0;

		// Received bytes
		if (rx_valid_i) begin
			unique case (st_q)
				ST_CMD: begin
					cmd_d = rx_byte_i;
					crc_d = crc_byte(CRC_CLEAR, rx_byte_i);
					idx_d = 4'h0;
					crcph_d = 2'd0;
					unique case (rx_byte_i)
						CMD_WSPAD: begin
							st_d = ST_TGT_LO;
							accepted_d = 1'b0;
							partial_d = 1'b0;
						end
						CMD_RMEM: st_d = ST_TGT_LO;
						CMD_RSPAD: begin
							st_d = ST_RSP;
							ptr_d = ta_q[4:0];
						end
						CMD_COPY: st_d = ST_AUTH;
						CMD_CLEAR, CMD_START, CMD_STOP: st_d = ST_PW;
						CMD_CONV: st_d = ST_DUMMY;
						default: st_d = ST_DEAD;
					endcase
				end
				ST_TGT_LO: begin
					ta_d[7:0] = rx_byte_i;
					crc_d = crc_byte(crc_q, rx_byte_i);
					st_d = ST_TGT_HI;
				end
				ST_TGT_HI: begin
					ta_d[15:8] = rx_byte_i;
					addr_d = {rx_byte_i, ta_q[7:0]};
					crc_d = crc_byte(crc_q, rx_byte_i);
					ptr_d = ta_q[4:0];
					full_d = 1'b0;
					st_d = (cmd_q == CMD_WSPAD) ? ST_WDATA : ST_PW;
				end
				ST_WDATA: begin
					// Bytes past offset 1Fh are dropped, scratchpad is full
					if (rx_partial_i) begin
						partial_d = 1'b1;
					end else if (!full_q) begin
						sp_we = 1'b1;
						es_off_d = ptr_q;
						full_d = ptr_q == OFF_LAST;
						ptr_d = ptr_q + 5'd1;
					end
				end
				ST_AUTH: begin
					auth_d = {rx_byte_i, auth_q[23:8]};
					idx_d = idx_q + 4'h1;
					if (idx_q == AUTH_LAST_IDX) begin
						idx_d = 4'h0;
						st_d = ST_PW;
					end
				end
				ST_PW: begin
					pw_d = pw_v;
					idx_d = idx_q + 4'h1;
					if (idx_q == PW_LAST_IDX) begin
						unique case (cmd_q)
							CMD_RMEM: begin
								st_d = read_ok ? ST_RMEM : ST_DEAD;
							end
							CMD_COPY: begin
								if (!full_ok) begin
									st_d = ST_DEAD;
								end else if (auth_q == {es_byte, ta_q}
									&& !(mission_in_progress_o
									&& ta_q >= REGP_LO
									&& ta_q <= REGP_HI)) begin
									accepted_d = 1'b1;
									ptr_d = ta_q[4:0];
									addr_d = ta_q;
									cnt_d = '0;
									st_d = ST_COPY;
								end else begin
									st_d = ST_ONES;
								end
							end
							default: begin
								st_d = full_ok ? ST_DUMMY : ST_DEAD;
							end
						endcase
					end
				end
				ST_DUMMY: begin
					unique case (cmd_q)
						CMD_CLEAR: begin
							st_d = mission_in_progress_o ? ST_DEAD : ST_ONES;
							mclr_d = !mission_in_progress_o;
							cleared_d = memory_cleared_o
								|| !mission_in_progress_o;
						end
						CMD_START: begin
							st_d = mission_in_progress_o ? ST_DEAD : ST_ONES;
							if (!mission_in_progress_o) begin
								mission_d = 1'b1;
								cleared_d = 1'b0;
								mstart_d = 1'b1;
								waiting_d = alarm_start_mode_i;
							end
						end
						CMD_STOP: begin
							st_d = mission_in_progress_o ? ST_ONES : ST_DEAD;
							mission_d = 1'b0;
						end
						default: begin
							st_d = mission_in_progress_o ? ST_DEAD : ST_CONV;
							cstart_d = !mission_in_progress_o;
							cnt_d = '0;
						end
					endcase
				end
				default: begin
				end
			endcase
		end

		// Read slots, one byte per request
		if (tx_req_i) begin
			tx_valid_d = 1'b1;
			tx_byte_d = FILL_ONES;
			unique case (st_q)
				ST_RSP: begin
					if (idx_q < HDR_BYTES) begin
						tx_byte_d = (idx_q == 4'h0) ? ta_q[7:0] :
							(idx_q == 4'h1) ? ta_q[15:8] : es_byte;
						crc_d = crc_byte(crc_q, tx_byte_d);
						idx_d = idx_q + 4'h1;
					end else if (crcph_q == 2'd0) begin
						tx_byte_d = sp_rdata;
						crc_d = crc_byte(crc_q, sp_rdata);
						crcph_d = (ptr_q == OFF_LAST) ? 2'd1 : 2'd0;
						ptr_d = ptr_q + 5'd1;
					end else if (crcph_q == 2'd1) begin
						tx_byte_d = ~crc_q[7:0];
						crcph_d = 2'd2;
					end else begin
						tx_byte_d = ~crc_q[15:8];
						st_d = ST_ONES;
					end
				end
				ST_RMEM: begin
					if (crcph_q == 2'd0) begin
						tx_byte_d = map_rd(addr_q, mem_rdata);
						crc_d = crc_byte(crc_q, tx_byte_d);
						crcph_d = (addr_q[4:0] == OFF_LAST) ? 2'd1 : 2'd0;
						addr_d = addr_q + 16'h0001;
					end else if (crcph_q == 2'd1) begin
						tx_byte_d = ~crc_q[7:0];
						crcph_d = 2'd2;
					end else begin
						tx_byte_d = ~crc_q[15:8];
						crc_d = CRC_CLEAR;
						crcph_d = 2'd0;
						if (addr_q > MEM_LAST || addr_q == 16'h0000) begin
							st_d = ST_ONES;
						end
					end
				end
				ST_ALT: tx_byte_d = FILL_ALT;
				default: begin
				end
			endcase
		end

		// Copy engine, one byte per COPY_CYC cycles
		if (st_q == ST_COPY) begin
			cnt_d = cnt_q + 1'b1;
			if (cnt_q == CNT_W'(COPY_CYC - 1)) begin
				mem_we = 1'b1;
				addr_d = addr_q + 16'h0001;
				ptr_d = ptr_q + 5'd1;
				cnt_d = '0;
				if (ptr_q == es_off_q) begin
					st_d = ST_ALT;
				end
			end
		end

		// Forced conversion, bounded by the worst-case time
		if (st_q == ST_CONV) begin
			cnt_d = cnt_q + 1'b1;
			if (conv_done_i) begin
				latest_d = conv_result_i;
				st_d = ST_ONES;
			end else if (cnt_q == CNT_W'(CONV_MAX_CYC_P - 1)) begin
				st_d = ST_ONES;
			end
		end

		// First alarm ends the wait; the sampler logs it uncounted
		if (waiting_for_alarm_o && mission_in_progress_o && alarm_hit_i) begin
			waiting_d = 1'b0;
			alog_d = 1'b1;
		end

		// Bus reset wins except while copying or converting
		if (bus_reset_i && st_q != ST_COPY && st_q != ST_CONV) begin
			st_d = ST_CMD;
			idx_d = 4'h0;
			crcph_d = 2'd0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= ST_CMD;
			cmd_q <= 8'h00;
			ta_q <= 16'h0000;
			addr_q <= 16'h0000;
			crc_q <= CRC_CLEAR;
			es_off_q <= 5'h00;
			ptr_q <= 5'h00;
			partial_q <= 1'b0;
			accepted_q <= 1'b0;
			full_q <= 1'b0;
			idx_q <= 4'h0;
			pw_q <= 64'h0000000000000000;
			auth_q <= 24'h000000;
			crcph_q <= 2'd0;
			cnt_q <= '0;
			tx_valid_o <= 1'b0;
			tx_byte_o <= 8'hff;
			mission_in_progress_o <= 1'b0;
			waiting_for_alarm_o <= 1'b0;
			memory_cleared_o <= 1'b0;
			reg_pages_writable_o <= 1'b1;
			authorization_accepted_o <= 1'b0;
			mission_start_o <= 1'b0;
			mission_clear_o <= 1'b0;
			alarm_log_o <= 1'b0;
			copy_busy_o <= 1'b0;
			conv_start_o <= 1'b0;
			latest_result_o <= 16'h0000;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			ta_q <= ta_d;
			addr_q <= addr_d;
			crc_q <= crc_d;
			es_off_q <= es_off_d;
			ptr_q <= ptr_d;
			partial_q <= partial_d;
			accepted_q <= accepted_d;
			full_q <= full_d;
			idx_q <= idx_d;
			pw_q <= pw_d;
			auth_q <= auth_d;
			crcph_q <= crcph_d;
			cnt_q <= cnt_d;
			tx_valid_o <= tx_valid_d;
			tx_byte_o <= tx_byte_d;
			mission_in_progress_o <= mission_d;
			waiting_for_alarm_o <= waiting_d;
			memory_cleared_o <= cleared_d;
			reg_pages_writable_o <= !mission_d;
			authorization_accepted_o <= accepted_d;
			mission_start_o <= mstart_d;
			mission_clear_o <= mclr_d;
			alarm_log_o <= alog_d;
			copy_busy_o <= st_d == ST_COPY;
			conv_start_o <= cstart_d;
			latest_result_o <= latest_d;
		end
	end
endmodule
`default_nettype wire

// ==== test/lmc_cmd_unit_properties.sv ====
/*
 * Concurrent checks on the command unit's ports.
 * Assumes a bind from the bench; one clock, async active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module lmc_cmd_unit_properties (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Watched ports
	input wire logic tx_req_i,
	input wire logic tx_valid_o,
	input wire logic alarm_hit_i,
	input wire logic conv_done_i,
	input wire logic [15:0] latest_result_o,
	input wire logic mission_in_progress_o,
	input wire logic waiting_for_alarm_o,
	input wire logic memory_cleared_o,
	input wire logic reg_pages_writable_o,
	input wire logic authorization_accepted_o,
	input wire logic mission_start_o,
	input wire logic mission_clear_o,
	input wire logic alarm_log_o,
	input wire logic copy_busy_o,
	input wire logic conv_start_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	// ------
	// Assertions
	// ------
	answer_timing_a: assert property ($past(tx_req_i) == tx_valid_o)
		else $error("answer not one cycle after request");
	pages_lock_a: assert property (reg_pages_writable_o != mission_in_progress_o)
		else $error("register page lock disagrees with mission");
	copy_length_a: assert property ($rose(copy_busy_o) |=> copy_busy_o[*8])
		else $error("copy ended too soon");
	copy_auth_a: assert property ($rose(copy_busy_o) |-> authorization_accepted_o)
		else $error("copy without accepted flag");
	start_flag_a: assert property (mission_start_o |-> ##[0:1] mission_in_progress_o)
		else $error("start without mission flag");
	clear_flag_a: assert property (mission_clear_o |-> !mission_in_progress_o ##[0:1] memory_cleared_o)
		else $error("clear in mission or flag not set");
	conv_idle_a: assert property (conv_start_o |-> !mission_in_progress_o)
		else $error("conversion during mission");
	result_load_a: assert property ($changed(latest_result_o) |-> $past(conv_done_i))
		else $error("result changed without conversion");
	stop_wait_a: assert property ($fell(mission_in_progress_o) |-> $stable(waiting_for_alarm_o))
		else $error("stop touched waiting flag");
	alarm_log_a: assert property (alarm_log_o |-> mission_in_progress_o && $past(alarm_hit_i))
		else $error("alarm log without mission alarm");

	// ------
	// Covers
	// ------
	cover property (mission_clear_o);
	cover property ($fell(copy_busy_o));
	cover property (conv_start_o ##[1:60] $changed(latest_result_o));
	cover property (alarm_log_o);
endmodule
`default_nettype wire

// ==== test/lmc_link_master.sv ====
/*
 * Byte-level link master standing in for the bus master.
 * Assumes the unit's link handshake; drives 1 ns after rising edges.
 */
`timescale 1ns/1ns
`default_nettype none
module lmc_link_master (
	// Clock
	input wire logic mclk_i,
	// Link toward the unit
	output logic bus_reset_o,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o,
	output logic rx_partial_o,
	output logic tx_req_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_byte_i
);
	initial begin
		bus_reset_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_partial_o = 1'b0;
		tx_req_o = 1'b0;
	end

	// ------
	// Link cycles
	// ------
	task automatic bus_rst();
		@(posedge mclk_i);
		#1 bus_reset_o = 1'b1;
		@(posedge mclk_i);
		#1 bus_reset_o = 1'b0;
	endtask

	// Released byte lines show the inverse, never the old value
	task automatic put(input logic [7:0] b);
		@(posedge mclk_i);
		#1 rx_valid_o = 1'b1;
		rx_byte_o = b;
		@(posedge mclk_i);
		#1 rx_valid_o = 1'b0;
		rx_byte_o = ~b;
	endtask

	// Two-cycle spacing keeps within the memory read latency
	task automatic get(output logic [7:0] b);
		@(posedge mclk_i);
		#1 tx_req_o = 1'b1;
		@(posedge mclk_i);
		#1 tx_req_o = 1'b0;
		b = (tx_valid_i === 1'b1) ? tx_byte_i : 8'hxx;
	endtask
endmodule
`default_nettype wire

// ==== test/test_lmc_cmd_unit.sv ====
/*
 * Self-checking bench of the command unit.
 * Assumes the link master model and the property checker.
 */
`timescale 1ns/1ns
`default_nettype none
module test_lmc_cmd_unit import lmc_pkg::*;;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic bus_reset_i, rx_valid_i, rx_partial_i, tx_req_i, tx_valid_o;
	logic [7:0] rx_byte_i, tx_byte_o, dat [32];
	logic pw_enable_i = 1'b1;
	logic [63:0] read_pw_i = 64'hfedcba9876543210;
	logic [63:0] full_pw_i = 64'h0123456789abcdef;
	logic alarm_start_mode_i = 1'b1, alarm_hit_i = 1'b0, conv_done_i = 1'b0;
	logic [15:0] conv_result_i = 16'h0000, latest_result_o, crc;
	logic mission_in_progress_o, waiting_for_alarm_o, memory_cleared_o;
	logic reg_pages_writable_o, authorization_accepted_o, mission_start_o;
	logic mission_clear_o, alarm_log_o, copy_busy_o, conv_start_o;
	int err_total = 0, tests_run = 0, cyc = 0;

	lmc_cmd_unit #(.CONV_MAX_CYC_P(50)) lmc_cmd_unit_inst (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .bus_reset_i(bus_reset_i),
		.rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
		.rx_partial_i(rx_partial_i), .tx_req_i(tx_req_i),
		.tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
		.pw_enable_i(pw_enable_i), .read_pw_i(read_pw_i),
		.full_pw_i(full_pw_i), .alarm_start_mode_i(alarm_start_mode_i),
		.alarm_hit_i(alarm_hit_i),
		.mission_in_progress_o(mission_in_progress_o),
		.waiting_for_alarm_o(waiting_for_alarm_o),
		.memory_cleared_o(memory_cleared_o),
		.reg_pages_writable_o(reg_pages_writable_o),
		.authorization_accepted_o(authorization_accepted_o),
		.mission_start_o(mission_start_o), .mission_clear_o(mission_clear_o),
		.alarm_log_o(alarm_log_o), .copy_busy_o(copy_busy_o),
		.conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
		.conv_start_o(conv_start_o), .latest_result_o(latest_result_o));

	lmc_link_master lmc_link_master_inst (
		.mclk_i(mclk_i), .bus_reset_o(bus_reset_i), .rx_valid_o(rx_valid_i),
		.rx_byte_o(rx_byte_i), .rx_partial_o(rx_partial_i),
		.tx_req_o(tx_req_i), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o));

	always #50 mclk_i = ~mclk_i;

	// ------
	// Helpers
	// ------
	function automatic logic [15:0] crc_b(input logic [15:0] c,
			input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
		return c;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic tx(input logic [7:0] b);
		lmc_link_master_inst.put(b);
		crc = crc_b(crc, b);
	endtask

	task automatic cmd(input logic [7:0] c);
		lmc_link_master_inst.bus_rst();
		crc = CRC_CLEAR;
		tx(c);
	endtask

	task automatic pw(input logic [63:0] p);
		for (int i = 0; i < 8; i++) lmc_link_master_inst.put(p[8*i+:8]);
	endtask

	task automatic rd_free(input logic [7:0] e);
		logic [7:0] g;
		lmc_link_master_inst.get(g);
		chk(g, e);
	endtask

	task automatic rd(input logic [7:0] e);
		rd_free(e);
		crc = crc_b(crc, e);
	endtask

	task automatic rd_crc();
		logic [15:0] c;
		c = ~crc;
		rd_free(c[7:0]);
		rd_free(c[15:8]);
	endtask

	task automatic wr_sp(input logic [7:0] lo, input logic [7:0] hi);
		cmd(CMD_WSPAD);
		tx(lo);
		tx(hi);
		for (int i = 0; i < 32; i++) tx(dat[i]);
	endtask

	// Copy authorization and a copy that may not start at all
	task automatic copy(input logic [7:0] hi);
		cmd(CMD_COPY);
		tx(8'h00);
		tx(hi);
		tx(8'h1f);
		pw(full_pw_i);
	endtask

	task automatic ctl(input logic [7:0] c);
		cmd(c);
		pw(full_pw_i);
		lmc_link_master_inst.put(FILL_ONES);
		repeat (2) @(posedge mclk_i);
		#1;
	endtask

	// ------
	// Sequence
	// ------
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		for (int i = 0; i < 32; i++) dat[i] = 8'(i * 7 + 3);
		repeat (2) @(posedge mclk_i);
		#1 rstn_i = 1'b1;
		wr_sp(8'h00, 8'h01);
		cmd(CMD_RSPAD);
		rd(8'h00);
		rd(8'h01);
		rd(8'h1f);
		for (int i = 0; i < 32; i++) rd(dat[i]);
		rd_crc();
		rd_free(FILL_ONES);
		copy(8'h01);
		repeat (100) @(posedge mclk_i);
		#1 chk(copy_busy_o, 1'b1);
		lmc_link_master_inst.bus_rst();
		for (int n = 0; n < 1000 && copy_busy_o !== 1'b0; n++) begin
			@(posedge mclk_i);
			#1;
		end
		chk(copy_busy_o, 1'b0);
		chk(authorization_accepted_o, 1'b1);
		rd_free(FILL_ALT);
		cmd(CMD_RSPAD);
		rd(8'h00);
		rd(8'h01);
		rd(8'h9f);
		cmd(CMD_RMEM);
		tx(8'h1e);
		tx(8'h01);
		pw(read_pw_i);
		for (int i = 30; i < 32; i++) rd(dat[i]);
		rd_crc();
		// Reserved space: two full pages, second CRC restarts cleared
		cmd(CMD_RMEM);
		tx(8'hc0);
		tx(8'h0f);
		pw(full_pw_i);
		for (int i = 0; i < 32; i++) rd(FILL_RSV);
		rd_crc();
		crc = CRC_CLEAR;
		for (int i = 0; i < 32; i++) rd(FILL_RSV);
		rd_crc();
		cmd(CMD_RMEM);
		tx(8'h00);
		tx(8'h01);
		pw(64'h0000000000000000);
		rd_free(FILL_ONES);
		ctl(CMD_CLEAR);
		chk(memory_cleared_o, 1'b1);
		cmd(CMD_CONV);
		lmc_link_master_inst.put(FILL_ONES);
		chk(conv_start_o, 1'b1);
		lmc_link_master_inst.bus_rst();
		rd_free(FILL_ONES);
		conv_done_i = 1'b1;
		conv_result_i = 16'h1a2b;
		@(posedge mclk_i);
		#1 conv_done_i = 1'b0;
		conv_result_i = 16'he5d4;
		@(posedge mclk_i);
		#1 chk(latest_result_o, 16'h1a2b);
		ctl(CMD_START);
		chk(mission_in_progress_o, 1'b1);
		chk(waiting_for_alarm_o, 1'b1);
		chk(reg_pages_writable_o, 1'b0);
		cmd(CMD_CONV);
		lmc_link_master_inst.put(FILL_ONES);
		chk(conv_start_o, 1'b0);
		ctl(CMD_CLEAR);
		rd_free(FILL_ONES);
		chk(memory_cleared_o, 1'b0);
		wr_sp(8'h00, 8'h02);
		chk(authorization_accepted_o, 1'b0);
		copy(8'h02);
		for (int n = 0; n < 1000 && copy_busy_o !== 1'b0; n++) begin
			@(posedge mclk_i);
			#1;
		end
		chk(authorization_accepted_o, 1'b0);
		ctl(CMD_STOP);
		chk(mission_in_progress_o, 1'b0);
		chk(waiting_for_alarm_o, 1'b1);
		chk(reg_pages_writable_o, 1'b1);
		// Restart so the alarm meets a waiting mission
		ctl(CMD_START);
		@(posedge mclk_i);
		#1 alarm_hit_i = 1'b1;
		@(posedge mclk_i);
		#1 alarm_hit_i = 1'b0;
		chk(alarm_log_o, 1'b1);
		chk(waiting_for_alarm_o, 1'b0);
		stop_test();
	end
endmodule

bind lmc_cmd_unit lmc_cmd_unit_properties lmc_cmd_unit_properties_inst (
	.mclk_i(mclk_i), .rstn_i(rstn_i), .tx_req_i(tx_req_i),
	.tx_valid_o(tx_valid_o), .alarm_hit_i(alarm_hit_i),
	.conv_done_i(conv_done_i), .latest_result_o(latest_result_o),
	.mission_in_progress_o(mission_in_progress_o),
	.waiting_for_alarm_o(waiting_for_alarm_o),
	.memory_cleared_o(memory_cleared_o),
	.reg_pages_writable_o(reg_pages_writable_o),
	.authorization_accepted_o(authorization_accepted_o),
	.mission_start_o(mission_start_o), .mission_clear_o(mission_clear_o),
	.alarm_log_o(alarm_log_o), .copy_busy_o(copy_busy_o),
	.conv_start_o(conv_start_o));
`default_nettype wire
